/* src/eer_pkg.sv */
package eer_pkg;

   // half-page result reported by the correction datapath
   typedef enum logic [1:0] {
      EER_RES_NONE   = 2'b00,
      EER_RES_SINGLE = 2'b01,
      EER_RES_DOUBLE = 2'b10
   } eer_res_e;

   // device density strap
   typedef enum logic [1:0] {
      EER_DENS_128 = 2'b00,
      EER_DENS_256 = 2'b01,
      EER_DENS_512 = 2'b10
   } eer_dens_e;

   localparam int ADDR_W = 25;

   // one half-page read result, sys_clk domain
   typedef struct packed {
      logic              valid;
      eer_res_e          res;
      logic              status_rd;
      logic              in_syndrome;
      logic              ecc_off;
      logic              multi_prog;
      logic [ADDR_W-1:0] addr;
   } eer_evt_s;

   // status word field positions
   localparam int ST_OFF_BIT  = 0;
   localparam int ST_DATA_BIT = 1;
   localparam int ST_SYN_BIT  = 2;
   localparam int ST_ONE_BIT  = 3;
   localparam int ST_TWO_BIT  = 4;

   // configuration bit positions
   localparam int CFG_TRAP_BOTH_BIT = 13;
   localparam int CFG_STALL_OFF_BIT = 2;

   // trap layout: lower holds A15..A3, upper holds A16 upward
   localparam int TRAP_LO_LSB = 3;
   localparam int TRAP_HI_LSB = 16;
   localparam int HP_ALIGN_W  = 3;

   // reset values and limits
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] TRAP_RST   = 16'h0000;
   localparam logic [15:0] CNT_RST    = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;

   // strap capture: second sync stage is valid from the third edge
   localparam logic [1:0]  STRAP_TAKE = 2'h2;
   localparam logic [1:0]  STRAP_DONE = 2'h3;

   // upper trap masks per density
   localparam logic [15:0] HI_MASK_128 = 16'h007F;
   localparam logic [15:0] HI_MASK_256 = 16'h00FF;
   localparam logic [15:0] HI_MASK_512 = 16'h01FF;

endpackage

/* src/eer_ecc_report.sv */
`timescale 1ns/1ns
// Operation
// - 16-bit status word reports addressed unit
// - bit 0 shows ecc off in unit
// - bit 1 shows unit data corrected
// - bit 2 shows check code corrected
// - bit 3 global sticky single correction
// - bit 4 global sticky double detection
// - bits 15 to 5 reserved, host ignores
// - status clears on reset and exit
// - trap keeps first enabled failing half-page
// - trap type selection depends on density
// - trap valid only with bit 3/4
// - exit clears trap and bits 4:3
// - multi-programmed half-page without detection ignored
// - counter counts main array errors only
// - counter saturates, never wraps
// - counter clears on reset or clear
// - counter commands only in status mode
// - one count per failing half-page read, none at largest density
// - stalled read keeps counting until deselect
// - double error holds strobe low till deselect
// - status bits appear in bits 4:0
module eer_ecc_report (
   // system clock and reset
   input  wire logic                sys_clk,
   input  wire logic                resetn,
   // half-page results from the correction datapath
   input  wire eer_pkg::eer_evt_s   evt,
   // mode and commands from the command decoder
   input  wire logic                overlay_active,
   input  wire logic                overlay_exit,
   input  wire logic                cnt_clear_req,
   input  wire logic                cnt_read_req,
   // configuration words
   input  wire logic [15:0]         protection_config_word,
   input  wire logic [15:0]         volatile_config_word,
   input  wire logic                double_error_detect,
   // density strap pins
   input  wire eer_pkg::eer_dens_e  dens_strap,
   // register read values
   output logic [15:0]              ecc_status_word_r,
   output logic [15:0]              error_address_low_r,
   output logic [15:0]              error_address_high_r,
   output logic [15:0]              error_count_r,
   output logic                     trap_valid_r,
   // link side
   input  wire logic                lnk_clk,
   input  wire logic                cs_n,
   input  wire logic                strobe_in,
   output logic                     read_data_strobe_r
);
   import eer_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // density strap, synchronised and caught once after release

   eer_dens_e  dens_s1_r;
   eer_dens_e  dens_s2_r;
   eer_dens_e  dens_r;
   logic [1:0] strap_cnt_r;
   // taking the second stage any earlier would latch its reset value
   wire        strap_take = (strap_cnt_r == STRAP_TAKE);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dens_s1_r   <= EER_DENS_128;
         dens_s2_r   <= EER_DENS_128;
         dens_r      <= EER_DENS_128;
         strap_cnt_r <= 2'h0;
      end else begin
         dens_s1_r <= dens_strap;
         dens_s2_r <= dens_s1_r;
         if (strap_cnt_r != STRAP_DONE) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
         end
         if (strap_take) begin
            dens_r <= dens_s2_r;
         end
      end
   end

   wire largest_dens = (dens_r == EER_DENS_512);

   ////////////////////////////////////////////////////////////////////////////
   // event qualification

   wire is_single = evt.valid && (evt.res == EER_RES_SINGLE);
   wire is_double = evt.valid && (evt.res == EER_RES_DOUBLE);
   // no detection and reprogrammed half-page: checking is off there
   wire chk_off   = !double_error_detect && evt.multi_prog;
   wire one_ok    = is_single && !chk_off;
   wire two_ok    = is_double && !chk_off;
   wire trap_both = protection_config_word[CFG_TRAP_BOTH_BIT];
   // largest density traps double errors only
   wire trap_hit  = two_ok || (one_ok && trap_both && !largest_dens);
   // status reads happen in overlay mode, so they never count
   wire cnt_hit   = (one_ok || two_ok) && !largest_dens
                    && !overlay_active && !evt.status_rd;

   ////////////////////////////////////////////////////////////////////////////
   // status word

   logic [2:0]  unit_bits_r;
   logic        one_seen_r;
   logic        two_seen_r;
   wire         unit_load  = evt.valid && evt.status_rd;
   wire [2:0]   unit_nxt   = {one_ok && evt.in_syndrome,
                              one_ok && !evt.in_syndrome,
                              evt.ecc_off};
   // set wins over the exit clear; the current status read may set too
   wire         one_nxt    = (one_seen_r && !overlay_exit) || one_ok;
   wire         two_nxt    = (two_seen_r && !overlay_exit) || two_ok;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         unit_bits_r <= 3'h0;
         one_seen_r  <= 1'b0;
         two_seen_r  <= 1'b0;
      end else begin
         one_seen_r  <= one_nxt;
         two_seen_r  <= two_nxt;
         if (unit_load) begin
            unit_bits_r <= unit_nxt;
         end else if (overlay_exit) begin
            unit_bits_r <= 3'h0;
         end
      end
   end

   // reserved bits are driven zero; bits 3:1 stand as-is even when bit 4
   // makes them invalid, the host is expected to discard them
   wire [15:0] status_nxt = {11'h000, two_seen_r, one_seen_r, unit_bits_r};

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ecc_status_word_r <= STATUS_RST;
         trap_valid_r      <= 1'b0;
      end else begin
         ecc_status_word_r <= status_nxt;
         trap_valid_r      <= one_seen_r || two_seen_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address trap

   logic        trap_full_r;
   wire  [15:0] hi_mask  = (dens_r == EER_DENS_512) ? HI_MASK_512 :
                           (dens_r == EER_DENS_256) ? HI_MASK_256 : HI_MASK_128;
   wire  [15:0] lo_addr  = {evt.addr[TRAP_HI_LSB-1:TRAP_LO_LSB], {HP_ALIGN_W{1'b0}}};
   wire  [15:0] hi_addr  = {7'h00, evt.addr[ADDR_W-1:TRAP_HI_LSB]} & hi_mask;
   // a hit in the exit cycle is kept: set wins
   wire         trap_ld  = trap_hit && (!trap_full_r || overlay_exit);
   wire         full_nxt = trap_hit || (trap_full_r && !overlay_exit);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trap_full_r          <= 1'b0;
         error_address_low_r  <= TRAP_RST;
         error_address_high_r <= TRAP_RST;
      end else begin
         trap_full_r <= full_nxt;
         if (trap_ld) begin
            error_address_low_r  <= lo_addr;
            error_address_high_r <= hi_addr;
         end else if (overlay_exit) begin
            error_address_low_r  <= TRAP_RST;
            error_address_high_r <= TRAP_RST;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error counter

   logic [15:0] err_cnt_r;
   wire         clr_ok  = cnt_clear_req && overlay_active;
   wire         rd_ok   = cnt_read_req && overlay_active;
   wire         cnt_inc = cnt_hit && (err_cnt_r != CNT_MAX);
   // exit leaves the count alone; clear and count never meet since
   // counting is blocked in overlay mode
   wire  [15:0] cnt_nxt = clr_ok  ? CNT_RST :
                          cnt_inc ? err_cnt_r + 16'h0001 : err_cnt_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         err_cnt_r     <= CNT_RST;
         error_count_r <= CNT_RST;
      end else begin
         err_cnt_r <= cnt_nxt;
         if (rd_ok) begin
            error_count_r <= err_cnt_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // double error events toward the link clock

   logic dbl_tgl_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dbl_tgl_r <= 1'b0;
      end else if (two_ok && !evt.status_rd) begin
         dbl_tgl_r <= !dbl_tgl_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain: strobe stall

   logic tg_s1_r;
   logic tg_s2_r;
   logic tg_s3_r;
   logic off_s1_r;
   logic off_s2_r;
   logic stall_r;

   always_ff @(posedge lnk_clk or negedge resetn) begin
      if (!resetn) begin
         tg_s1_r  <= 1'b0;
         tg_s2_r  <= 1'b0;
         tg_s3_r  <= 1'b0;
         off_s1_r <= 1'b0;
         off_s2_r <= 1'b0;
      end else begin
         tg_s1_r  <= dbl_tgl_r;
         tg_s2_r  <= tg_s1_r;
         tg_s3_r  <= tg_s2_r;
         off_s1_r <= volatile_config_word[CFG_STALL_OFF_BIT];
         off_s2_r <= off_s1_r;
      end
   end

   wire dbl_seen  = tg_s2_r ^ tg_s3_r;
   wire stall_set = dbl_seen && !off_s2_r && !cs_n;

   // the link clock may stop once deselected, so chip select itself
   // drops the stall without waiting for another edge
   always_ff @(posedge lnk_clk or negedge resetn or posedge cs_n) begin
      if (!resetn) begin
         stall_r <= 1'b0;
      end else if (cs_n) begin
         stall_r <= 1'b0;
      end else if (stall_set) begin
         stall_r <= 1'b1;
      end
   end

   // the host times the frozen strobe out after 32 cycles; the device
   // keeps the data path and counter running meanwhile
   always_ff @(posedge lnk_clk or negedge resetn) begin
      if (!resetn) begin
         read_data_strobe_r <= 1'b0;
      end else begin
         read_data_strobe_r <= strobe_in && !stall_r && !stall_set && !cs_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      ecc_status_word_r[15:5] == 11'h000)
      else $error("reserved status bits not zero");

   a_unit_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      unit_load |=> ##1 ecc_status_word_r[2:0] == $past(unit_nxt, 2))
      else $error("unit status bits not reported");

   a_unit_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
      overlay_exit && !unit_load |=> ##1 ecc_status_word_r[2:0] == 3'h0)
      else $error("unit status bits kept over exit");

   a_single_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
      one_ok |-> ##2 ecc_status_word_r[ST_ONE_BIT])
      else $error("single correction flag not set");

   a_double_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
      two_seen_r && !overlay_exit |=> two_seen_r)
      else $error("double flag lost without exit");

   a_exit_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
      overlay_exit && !evt.valid |=> !one_seen_r && !two_seen_r && !trap_full_r
      ##1 ecc_status_word_r[4:3] == 2'b00)
      else $error("exit did not clear flags and trap");

   a_trap_valid: assert property (@(posedge sys_clk) disable iff (!resetn)
      trap_valid_r == (ecc_status_word_r[ST_ONE_BIT] || ecc_status_word_r[ST_TWO_BIT]))
      else $error("trap valid differs from status flags");

   a_trap_aligned: assert property (@(posedge sys_clk) disable iff (!resetn)
      trap_hit && !trap_full_r |=> error_address_low_r == {$past(evt.addr[15:3]), 3'h0})
      else $error("trap does not hold aligned half-page");

   a_trap_first: assert property (@(posedge sys_clk) disable iff (!resetn)
      trap_full_r && !overlay_exit |=> $stable(error_address_low_r)
      && $stable(error_address_high_r))
      else $error("trap overwritten");

   a_trap_big_dens: assert property (@(posedge sys_clk) disable iff (!resetn)
      largest_dens && is_single && !trap_full_r && !two_ok |=> !trap_full_r)
      else $error("single error trapped on largest density");

   a_chk_off_skip: assert property (@(posedge sys_clk) disable iff (!resetn)
      evt.valid && chk_off |=> $stable(err_cnt_r) || $past(clr_ok))
      else $error("ignored half-page counted");

   a_chk_off_trap: assert property (@(posedge sys_clk) disable iff (!resetn)
      evt.valid && chk_off && !trap_full_r |=> !trap_full_r)
      else $error("ignored half-page trapped");

   a_cnt_overlay: assert property (@(posedge sys_clk) disable iff (!resetn)
      overlay_active && !clr_ok |=> err_cnt_r == $past(err_cnt_r))
      else $error("counter moved in overlay mode");

   a_cnt_largest: assert property (@(posedge sys_clk) disable iff (!resetn)
      largest_dens && !clr_ok |=> $stable(err_cnt_r))
      else $error("counter moved on largest density");

   a_cnt_saturate: assert property (@(posedge sys_clk) disable iff (!resetn)
      err_cnt_r == CNT_MAX && !clr_ok |=> err_cnt_r == CNT_MAX)
      else $error("counter wrapped");

   a_cnt_step: assert property (@(posedge sys_clk) disable iff (!resetn)
      cnt_hit && err_cnt_r != CNT_MAX |=> err_cnt_r == $past(err_cnt_r) + 16'h0001)
      else $error("failing half-page not counted once");

   a_cnt_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
      cnt_clear_req && !overlay_active && !cnt_hit |=> $stable(err_cnt_r))
      else $error("clear accepted outside overlay");

   a_exit_keeps_cnt: assert property (@(posedge sys_clk) disable iff (!resetn)
      overlay_exit && overlay_active && !clr_ok |=> $stable(err_cnt_r))
      else $error("exit changed counter");

   a_stall_low: assert property (@(posedge lnk_clk) disable iff (!resetn)
      stall_r && !cs_n |=> !read_data_strobe_r)
      else $error("strobe toggled during stall");

   a_stall_arms: assert property (@(posedge lnk_clk) disable iff (!resetn)
      stall_set ##1 !cs_n |-> stall_r)
      else $error("stall not armed after double error");

   a_stall_disabled: assert property (@(posedge lnk_clk) disable iff (!resetn)
      off_s2_r && !stall_r |=> !stall_r)
      else $error("stall armed while disabled");

   a_strobe_normal: assert property (@(posedge lnk_clk) disable iff (!resetn)
      !cs_n && !stall_r && !stall_set |=> read_data_strobe_r == $past(strobe_in))
      else $error("strobe not passed through");

   a_deselect_idle: assert property (@(posedge lnk_clk) disable iff (!resetn)
      cs_n |=> !read_data_strobe_r)
      else $error("strobe active while deselected");

   c_trap_double: cover property (@(posedge sys_clk) disable iff (!resetn)
      two_ok && !trap_full_r ##1 trap_full_r);

   c_cnt_sat: cover property (@(posedge sys_clk) disable iff (!resetn)
      cnt_hit && err_cnt_r == CNT_MAX);

   c_exit_evt: cover property (@(posedge sys_clk) disable iff (!resetn)
      overlay_exit && trap_hit);

   c_stall: cover property (@(posedge lnk_clk) disable iff (!resetn)
      stall_set ##1 stall_r [*3]);

   c_unit_syn: cover property (@(posedge sys_clk) disable iff (!resetn)
      unit_load && one_ok && evt.in_syndrome);

endmodule

/* sim/eer_host_model.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// host controller on the link: selects the device, feeds a toggling strobe
// source and raises a bus error once the returned strobe stays still too long
module eer_host_model (
   // link clock and bench control
   input  wire logic lnk_clk,
   input  wire logic sel,
   // link signals
   input  wire logic rds,
   output logic      cs_n,
   output logic      strobe_in,
   output logic      bus_err
);
   logic [5:0] still = 6'h00;
   logic       rds_q = 1'b0;
   initial begin
      cs_n = 1'b1;
      strobe_in = 1'b0;
      bus_err = 1'b0;
   end
   // select and strobe change half a link cycle away from sampling
   always @(negedge lnk_clk) begin
      cs_n      <= !sel;
      strobe_in <= sel ? !strobe_in : 1'b0;
   end
   always @(posedge lnk_clk) begin
      rds_q <= rds;
      if (cs_n) begin
         still   <= 6'h00;
         bus_err <= 1'b0;
      end else if (rds == rds_q) begin
         still <= (still == 6'h3F) ? still : still + 6'h01;
         if (still > 6'h20) begin
            bus_err <= 1'b1;
         end
      end else begin
         still <= 6'h00;
      end
   end
endmodule

/* sim/eer_ecc_report_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
   $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
//////////////////////////////////////////////////////////////////////////////
module eer_ecc_report_tb_top;
   import eer_pkg::*;
   logic        sys_clk = 1'b0;
   logic        lnk_clk = 1'b0;
   logic        resetn = 1'b0;
   eer_evt_s    evt = '0;
   logic        ovl = 1'b0, ovl_exit = 1'b0, clr = 1'b0, rdc = 1'b0;
   logic        dbl_det = 1'b1, sel = 1'b0;
   eer_dens_e   dens = EER_DENS_256;
   logic [15:0] pcw = 16'h0000, vcw = 16'h0000;
   logic [15:0] st, tlo, thi, cnt;
   logic        tv, rds, cs_n, stb, bus_err;
   int          errors = 0, samples_checked = 0, exp_cnt = 0;

   always #2 sys_clk = !sys_clk;
   // odd-time edges keep the link clock off the system clock edges
   initial begin
      #1;
      forever #6 lnk_clk = !lnk_clk;
   end

   eer_ecc_report u_dut (.sys_clk(sys_clk), .resetn(resetn), .evt(evt),
      .overlay_active(ovl), .overlay_exit(ovl_exit), .cnt_clear_req(clr),
      .cnt_read_req(rdc), .protection_config_word(pcw), .volatile_config_word(vcw),
      .double_error_detect(dbl_det), .dens_strap(dens),
      .ecc_status_word_r(st), .error_address_low_r(tlo), .error_address_high_r(thi),
      .error_count_r(cnt), .trap_valid_r(tv), .lnk_clk(lnk_clk), .cs_n(cs_n),
      .strobe_in(stb), .read_data_strobe_r(rds));
   eer_host_model u_host (.lnk_clk(lnk_clk), .sel(sel), .rds(rds), .cs_n(cs_n),
      .strobe_in(stb), .bus_err(bus_err));

   //////////////////////////////////////////////////////////////////////////
   task automatic ev(eer_res_e r, logic [24:0] a, logic srd = 0, logic syn = 0,
                     logic off = 0, logic mp = 0);
      evt = '{1'b1, r, srd, syn, off, mp, a};
      @(negedge sys_clk);
   endtask
   task automatic settle();
      evt.valid = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic lwait(int n);
      repeat (n) @(negedge lnk_clk);
      @(negedge sys_clk);
   endtask
   task automatic chk_cnt(int e);
      ovl = 1'b1;
      pulse(rdc);
      ovl = 1'b0;
      `CHK("count", e[15:0], cnt)
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK("status", 16'h0000, st)
      `CHK("trap lo", 16'h0000, tlo)
      chk_cnt(0);
      $display("test reset done");
   endtask
   // status reads in overlay mode are never counted
   task automatic t_status();
      ovl = 1'b1;
      ev(EER_RES_NONE, 25'h10, 1, 0, 1);
      settle();
      `CHK("off bit", 16'h0001, st)
      ev(EER_RES_SINGLE, 25'h20, 1);
      settle();
      `CHK("data fix", 16'h000A, st)
      ev(EER_RES_SINGLE, 25'h30, 1, 1);
      settle();
      `CHK("syn fix", 16'h000C, st)
      `CHK("trap valid", 1'b1, tv)
      `CHK("single no trap", 16'h0000, tlo)
      pulse(ovl_exit);
      repeat (2) @(negedge sys_clk);
      `CHK("exit status", 16'h0000, st)
      ovl = 1'b0;
      chk_cnt(0);
      $display("test status done");
   endtask
   task automatic t_trap();
      ev(EER_RES_DOUBLE, 25'h1ABCDEF);
      ev(EER_RES_DOUBLE, 25'h0012340);
      ev(EER_RES_DOUBLE, 25'h1ABCDEF);
      settle();
      exp_cnt = 3;
      `CHK("two bit", 16'h0010, st)
      `CHK("trap lo", 16'hCDE8, tlo)
      `CHK("trap hi", 16'h00AB, thi)
      dbl_det = 1'b0;
      ev(EER_RES_SINGLE, 25'h40, 0, 0, 0, 1);
      settle();
      dbl_det = 1'b1;
      `CHK("multi prog", 16'h0010, st)
      chk_cnt(exp_cnt);
      pulse(clr);
      chk_cnt(exp_cnt);
      ovl = 1'b1;
      pulse(ovl_exit);
      ovl = 1'b0;
      repeat (2) @(negedge sys_clk);
      `CHK("exit trap", 16'h0000, tlo)
      `CHK("exit valid", 1'b0, tv)
      chk_cnt(exp_cnt);
      pcw = 16'h2000;
      ev(EER_RES_SINGLE, 25'h0005557);
      settle();
      `CHK("one bit", 16'h0008, st)
      `CHK("single trap", 16'h5550, tlo)
      pcw = 16'h0000;
      $display("test trap done");
   endtask
   // two more errors than the counter holds, all back to back
   task automatic t_sat();
      ovl = 1'b1;
      pulse(clr);
      ovl = 1'b0;
      chk_cnt(0);
      for (int i = 0; i < 65537; i++) begin
         ev(EER_RES_SINGLE, 25'h100);
      end
      settle();
      chk_cnt(65535);
      $display("test saturate done");
   endtask
   task automatic t_stall();
      ovl = 1'b1;
      pulse(clr);
      ovl = 1'b0;
      sel = 1'b1;
      lwait(40);
      `CHK("normal strobe", 1'b0, bus_err)
      ev(EER_RES_DOUBLE, 25'h200);
      settle();
      lwait(5);
      `CHK("strobe low", 1'b0, rds)
      lwait(1);
      `CHK("strobe held", 1'b0, rds)
      ev(EER_RES_DOUBLE, 25'h210);
      ev(EER_RES_SINGLE, 25'h220);
      settle();
      lwait(40);
      `CHK("stalled", 1'b1, bus_err)
      sel = 1'b0;
      lwait(3);
      sel = 1'b1;
      lwait(40);
      `CHK("resumed", 1'b0, bus_err)
      vcw = 16'h0004;
      lwait(3);
      ev(EER_RES_DOUBLE, 25'h230);
      settle();
      lwait(40);
      `CHK("stall off", 1'b0, bus_err)
      sel = 1'b0;
      vcw = 16'h0000;
      chk_cnt(4);
      $display("test stall done");
   endtask
   // the strap is caught once, so the largest density needs a fresh reset
   task automatic t_big();
      dens = EER_DENS_512;
      resetn = 1'b0;
      repeat (8) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (5) @(negedge sys_clk);
      `CHK("reset count", 16'h0000, cnt)
      pcw = 16'h2000;
      ev(EER_RES_SINGLE, 25'h0001238);
      settle();
      `CHK("big single", 16'h0008, st)
      `CHK("big no trap", 16'h0000, tlo)
      ev(EER_RES_DOUBLE, 25'h1FEDCBA);
      settle();
      `CHK("big trap lo", 16'hDCB8, tlo)
      `CHK("big trap hi", 16'h01FE, thi)
      pcw = 16'h0000;
      chk_cnt(0);
      $display("test density done");
   endtask

   // tests take about 66k system cycles, nearly all in the saturation run
   initial begin
      #300000;
      errors++;
      give_verdict();
   end
   initial begin
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (5) @(negedge sys_clk);
      t_reset();
      t_status();
      t_trap();
      t_sat();
      t_stall();
      t_big();
      give_verdict();
   end
endmodule
